// *** hdl/ilr_pkg.sv ***
// Package: register map, field layout, timing and state types of the line block.
package ilr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_DATA_IN = 6'h00;
    localparam logic [5:0] IDX_PASS    = 6'h0A;
    localparam logic [5:0] IDX_EOS     = 6'h0E;
    localparam logic [5:0] IDX_TIMING  = 6'h11;
    localparam logic [5:0] IDX_SIG     = 6'h17;
    localparam logic [5:0] IDX_DRIVE   = 6'h1B;
    localparam logic [5:0] IDX_AUX     = 6'h20;
    localparam logic [5:0] IDX_HSCTL   = 6'h21;
    localparam logic [5:0] IDX_LONG    = 6'h22;
    localparam logic [5:0] IDX_ISTAT   = 6'h23;
    localparam logic [5:0] IDX_IMASK   = 6'h24;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] HOLD_TAG      = 3'h4;
    localparam logic [2:0] SETUP_TAG     = 3'h6;
    localparam logic [7:0] HOLD_RST      = 8'h80;
    localparam logic [7:0] SETUP_RST     = 8'hC0;
    localparam int         HSC_PEND_BIT  = 0;
    localparam int         HSC_FIXED_BIT = 4;
    localparam int         HSC_HS_BIT    = 7;
    localparam logic [7:0] LONG_DLY_RST  = 8'h10;

    // ------------------------------------------------------------------
    // Event bits of the interrupt status register
    // ------------------------------------------------------------------
    localparam int EV_CMD_OUT = 0;
    localparam int EV_CMD     = 1;
    localparam int EV_RX_END  = 2;
    localparam int EV_TX_DONE = 3;
    localparam int EV_W       = 4;

    // ------------------------------------------------------------------
    // Timing: one delay unit is one 25 ns period
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         TICK_NS        = 25;
    localparam int         TICK_CYC       = TICK_NS / CLK_PERIOD_NS;
    localparam int         FIXED_SETUP_NS = 75;
    localparam logic [7:0] FIXED_SETUP_U  = 8'(FIXED_SETUP_NS / TICK_NS);
    localparam logic [7:0] HOLD_BASE_U    = 8'h02;
    localparam logic [7:0] SETUP_BASE_U   = 8'h04;

    typedef enum logic [1:0] {SRC_IDLE, SRC_SGNS, SRC_STRS} ilr_src_t;

    typedef struct packed {
        logic wrap;
        logic eight_bit_compare_select;
        logic tx_en;
        logic rx_en;
    } ilr_aux_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic [7:0]  cpt;
        logic [7:0]  din;
        logic [7:0]  eos;
        logic [4:0]  hold;
        logic [4:0]  setup;
        logic [7:0]  drive;
        ilr_aux_t    aux;
        logic        hs_en;
        logic        fixed_short;
        logic        pend_end;
        logic [7:0]  long_dly;
        logic [EV_W-1:0] istat;
        logic [EV_W-1:0] imask;
        ilr_src_t    src;
        logic [7:0]  txb;
        logic        tx_eoi;
        logic [7:0]  units;
        logic [2:0]  pre;
        logic [7:0]  tgt;
        logic [7:0]  dio_lvl;
        logic [7:0]  dio_oe;
        logic        dav;
        logic        eoi;
        logic        tx_rdy;
        logic        rx_end;
    } ilr_state_t;

endpackage

// *** hdl/ilr_line_regs.sv ***
// Line, end-of-string and timing register block with its byte source.
//
// Notes on behaviour
// - Parallel poll result loads read-only pass-through.
// - A received command byte loads pass-through unless a poll result comes in the same cycle.
// - Signature register: version nibble, other bits constant.
// - High-speed Handshake_hold_time is 25 ns times (2+field).
// - Line-drive bits assert DIO unless loopback.
// - Fixed short setup gives 75 ns.
// - Otherwise setup is 25 ns times (4+field).
// - Setup delay times SGNS to STRS move.
// - Legacy data-in keeps last accepted byte.
// - Line status reads live DIO outside loopback, one means asserted.
// - Receive compare enabled: match raises END.
// - Compare width selects seven or eight bits.
// - Transmit compare: matching byte goes with EOI.
// - Shared offset: status read, tagged hold/setup writes.
// - Pending-with-end uses long delay for end byte.
`timescale 1ns/1ps
module ilr_line_regs
    import ilr_pkg::*;
#(
    parameter logic [3:0] SIG_VERSION = 4'h5,  // Arbitrary value.
    parameter logic [3:0] SIG_LOW     = 4'h0   // Arbitrary value.
) (
    input  wire logic        core_clk_i,    // Block clock, 200 MHz.
    input  wire logic        srst_i,        // Synchronous reset, high.
    input  wire logic        psel_i,        // APB select.
    input  wire logic        penable_i,     // APB enable.
    input  wire logic        pwrite_i,      // APB direction, 1 write.
    input  wire logic [7:0]  paddr_i,       // APB byte address.
    input  wire logic [31:0] pwdata_i,      // APB write data.
    output logic      [31:0] prdata_o,      // APB read data.
    output logic             pready_o,      // APB ready.
    output logic             pslverr_o,     // APB error, unmapped.
    output logic             irq_o,         // Level interrupt.
    input  wire logic        cmd_vld_i,     // Command byte received.
    input  wire logic [7:0]  cmd_data_i,    // Command byte.
    input  wire logic        ppoll_done_i,  // Parallel poll finished.
    input  wire logic [7:0]  ppoll_data_i,  // Parallel poll result.
    input  wire logic        rx_vld_i,      // Data byte accepted.
    input  wire logic [7:0]  rx_data_i,     // Accepted data byte.
    output logic             rx_end_o,      // End character matched.
    input  wire logic        tx_vld_i,      // Byte offered to source.
    input  wire logic [7:0]  tx_data_i,     // Byte to source.
    input  wire logic        tx_last_i,     // Byte is last, send EOI.
    output logic             tx_rdy_o,      // Source takes a byte.
    input  wire logic [7:0]  dio_i,         // DIO lines, 1 asserted.
    output logic      [7:0]  dio_o,         // DIO drive level, low.
    output logic      [7:0]  dio_oe_o,      // DIO enable, 1 asserts.
    input  wire logic        nrfd_i,        // Listener not ready.
    input  wire logic        ndac_i,        // Listener not accepted.
    output logic             dav_o,         // DAV asserted.
    output logic             eoi_o          // EOI asserted.
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic eos_match(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       eight);
        eos_match = eight ? (a == b) : (a[6:0] == b[6:0]);
    endfunction

    function automatic logic is_mapped(input logic [5:0] idx);
        case (idx)
            IDX_DATA_IN, IDX_PASS, IDX_EOS, IDX_TIMING, IDX_SIG,
            IDX_DRIVE, IDX_AUX, IDX_HSCTL, IDX_LONG, IDX_ISTAT,
            IDX_IMASK: is_mapped = 1'b1;
            default:   is_mapped = 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    ilr_state_t r;
    ilr_state_t n;
    logic [5:0] idx_w;
    logic       acc_w;
    logic       commit_w;
    logic [7:0] line_stat_w;

    assign idx_w    = paddr_i[7:2];
    assign acc_w    = psel_i && penable_i;
    assign commit_w = acc_w && r.pready;

    // In loopback nothing reaches the bus, so status shows our own drive.
    assign line_stat_w = r.aux.wrap
                       ? (r.drive | ((r.src != SRC_IDLE) ? r.txb : 8'h00))
                       : dio_i;

    always_comb begin
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] w1c;
        logic [7:0]      rd;
        logic [7:0]      setup_u;
        logic [7:0]      hold_u;
        logic            elapsed;
        ev      = '0;
        w1c     = '0;
        rd      = 8'h00;
        n       = r;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        n.rx_end  = 1'b0;
        setup_u = r.fixed_short ? FIXED_SETUP_U
                                : SETUP_BASE_U + {3'h0, r.setup};
        hold_u  = (r.pend_end && eos_match(r.txb, r.eos, r.aux.eight_bit_compare_select))
                ? r.long_dly
                : HOLD_BASE_U + {3'h0, r.hold};
        elapsed = (r.units >= r.tgt);

        // --------------------------------------------------------------
        // APB: ready one cycle into the access phase, write commits then
        // --------------------------------------------------------------
        case (idx_w)
            IDX_DATA_IN: rd = r.din;
            IDX_PASS:    rd = r.cpt;
            IDX_TIMING:  rd = line_stat_w;
            IDX_SIG:     rd = {SIG_VERSION, SIG_LOW};
            IDX_AUX:     rd = {4'h0, r.aux};
            IDX_HSCTL:   rd = {r.hs_en, 2'h0, r.fixed_short, 3'h0,
                               r.pend_end};
            IDX_LONG:    rd = r.long_dly;
            IDX_ISTAT:   rd = {4'h0, r.istat};
            IDX_IMASK:   rd = {4'h0, r.imask};
            default:     rd = 8'h00;
        endcase
        if (acc_w && !r.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !is_mapped(idx_w);
            n.prdata  = pwrite_i ? 32'h0 : {24'h0, rd};
        end
        if (commit_w && pwrite_i) begin
            case (idx_w)
                IDX_EOS:   n.eos = pwdata_i[7:0];
                IDX_TIMING: begin
                    if (pwdata_i[7:5] == HOLD_TAG) begin
                        n.hold = pwdata_i[4:0];
                    end else if (pwdata_i[7:5] == SETUP_TAG) begin
                        n.setup = pwdata_i[4:0];
                    end
                end
                IDX_DRIVE: n.drive = pwdata_i[7:0];
                IDX_AUX:   n.aux = ilr_aux_t'(pwdata_i[3:0]);
                IDX_HSCTL: begin
                    n.hs_en       = pwdata_i[HSC_HS_BIT];
                    n.fixed_short = pwdata_i[HSC_FIXED_BIT];
                    n.pend_end    = pwdata_i[HSC_PEND_BIT];
                end
                IDX_LONG:  n.long_dly = pwdata_i[7:0];
                IDX_ISTAT: w1c = pwdata_i[EV_W-1:0];
                IDX_IMASK: n.imask = pwdata_i[EV_W-1:0];
                default: begin
                end
            endcase
        end

        // --------------------------------------------------------------
        // Listener side and command capture
        // --------------------------------------------------------------
        if (rx_vld_i) begin
            n.din = rx_data_i;
            if (r.aux.rx_en && eos_match(rx_data_i, r.eos, r.aux.eight_bit_compare_select)) begin
                n.rx_end = 1'b1;
                ev[EV_RX_END] = 1'b1;
            end
        end
        if (cmd_vld_i) begin
            n.cpt = cmd_data_i;
            ev[EV_CMD] = 1'b1;
        end
        // A poll result wins over a command byte in the same cycle.
        if (ppoll_done_i) begin
            n.cpt = ppoll_data_i;
            ev[EV_CMD_OUT] = 1'b1;
        end

        // --------------------------------------------------------------
        // Source: SGNS times the setup, STRS times the Handshake_hold_time
        // --------------------------------------------------------------
        if (r.src != SRC_IDLE) begin
            if (r.pre == 3'(TICK_CYC - 1)) begin
                n.pre   = 3'h0;
                n.units = r.units + 8'h01;
            end else begin
                n.pre = r.pre + 3'h1;
            end
        end
        case (r.src)
            SRC_IDLE: begin
                if (tx_vld_i && r.tx_rdy) begin
                    n.txb    = tx_data_i;
                    n.tx_eoi = tx_last_i || (r.aux.tx_en &&
                               eos_match(tx_data_i, r.eos, r.aux.eight_bit_compare_select));
                    n.src    = SRC_SGNS;
                    n.pre    = 3'h0;
                    n.units  = 8'h00;
                    n.tgt    = 8'h00;
                end
            end
            SRC_SGNS: begin
                if (r.tgt == 8'h00 && r.units == 8'h00 && r.pre == 3'h0) begin
                    n.tgt = setup_u;
                end else if (elapsed && !nrfd_i) begin
                    n.src   = SRC_STRS;
                    n.pre   = 3'h0;
                    n.units = 8'h00;
                    n.tgt   = hold_u;
                end
            end
            SRC_STRS: begin
                // Outside high-speed mode the listener must also accept.
                if (elapsed && (r.hs_en || !ndac_i)) begin
                    n.src = SRC_IDLE;
                    ev[EV_TX_DONE] = 1'b1;
                end
            end
            default: n.src = SRC_IDLE;
        endcase

        // --------------------------------------------------------------
        // Pins and interrupt
        // --------------------------------------------------------------
        n.dio_oe = r.aux.wrap ? 8'h00
                 : (n.drive | ((n.src != SRC_IDLE) ? n.txb : 8'h00));
        n.dav    = (n.src == SRC_STRS) && !r.aux.wrap;
        n.eoi    = (n.src != SRC_IDLE) && n.tx_eoi && !r.aux.wrap;
        n.tx_rdy = (n.src == SRC_IDLE);
        // An event in the clearing cycle stays set.
        n.istat  = (r.istat & ~w1c) | ev;
        n.irq    = |(n.istat & n.imask);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            r          <= '0;
            r.long_dly <= LONG_DLY_RST;
        end else begin
            r <= n;
        end
    end

    assign prdata_o  = r.prdata;
    assign pready_o  = r.pready;
    assign pslverr_o = r.pslverr;
    assign irq_o     = r.irq;
    assign rx_end_o  = r.rx_end;
    assign tx_rdy_o  = r.tx_rdy;
    assign dio_o     = r.dio_lvl;
    assign dio_oe_o  = r.dio_oe;
    assign dav_o     = r.dav;
    assign eoi_o     = r.eoi;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Cycles spent in the current source state, for the timing checks.
    logic [11:0] stay_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i || n.src != r.src) begin
            stay_q <= 12'h000;
        end else if (stay_q != 12'hFFF) begin
            stay_q <= stay_q + 12'h001;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    AST_POLL_LOAD: assert property (
        ppoll_done_i |=> r.cpt == $past(ppoll_data_i))
        else $error("Poll result not in pass-through register.");

    AST_CMD_LOAD: assert property (
        cmd_vld_i && !ppoll_done_i |=> r.cpt == $past(cmd_data_i))
        else $error("Command byte not in pass-through register.");

    AST_SIG_READ: assert property (
        $rose(pready_o) && !pwrite_i && idx_w == IDX_SIG
        |-> prdata_o == {24'h0, SIG_VERSION, SIG_LOW})
        else $error("Signature read wrong.");

    AST_HOLD_TIME: assert property (
        r.src == SRC_STRS && n.src != SRC_STRS
        |-> {4'h0, r.tgt} * 12'(TICK_CYC) <= stay_q + 12'h001)
        else $error("DAV released before hold time.");

    sequence sgns_enter_s;
        r.src == SRC_IDLE ##1 r.src == SRC_SGNS;
    endsequence

    AST_SETUP_LOAD: assert property (
        sgns_enter_s ##0 !r.fixed_short
        |=> r.tgt == SETUP_BASE_U + {3'h0, $past(r.setup)})
        else $error("Setup target wrong.");

    AST_FIXED_SETUP: assert property (
        sgns_enter_s ##0 r.fixed_short |=> r.tgt == FIXED_SETUP_U)
        else $error("Fixed setup not 75 ns.");

    AST_SETUP_TIME: assert property (
        r.src == SRC_SGNS && n.src == SRC_STRS
        |-> {4'h0, r.tgt} * 12'(TICK_CYC) <= stay_q + 12'h001)
        else $error("Left SGNS before setup delay.");

    AST_DRIVE: assert property (
        commit_w && pwrite_i && idx_w == IDX_DRIVE && !r.aux.wrap &&
        r.src == SRC_IDLE && !(tx_vld_i && r.tx_rdy)
        |=> dio_oe_o == $past(pwdata_i[7:0]))
        else $error("Line drive not applied.");

    AST_WRAP_QUIET: assert property (
        r.aux.wrap ##1 r.aux.wrap |-> dio_oe_o == 8'h00 && !dav_o)
        else $error("Bus driven in loopback.");

    AST_LEGACY: assert property (
        rx_vld_i |=> r.din == $past(rx_data_i))
        else $error("Legacy data-in not updated.");

    AST_STATUS_READ: assert property (
        $rose(pready_o) && !pwrite_i && idx_w == IDX_TIMING &&
        !$past(r.aux.wrap) |-> prdata_o[7:0] == $past(dio_i))
        else $error("Line status not live.");

    AST_RX_END: assert property (
        rx_vld_i && r.aux.rx_en && r.aux.eight_bit_compare_select && rx_data_i == r.eos
        |=> rx_end_o ##1 (!rx_end_o || $past(rx_vld_i)))
        else $error("End character not flagged.");

    AST_RX_7BIT: assert property (
        rx_vld_i && r.aux.rx_en && !r.aux.eight_bit_compare_select &&
        rx_data_i[6:0] == r.eos[6:0] |=> rx_end_o)
        else $error("Seven-bit compare failed.");

    AST_TX_EOI: assert property (
        tx_vld_i && r.tx_rdy && r.aux.tx_en && !r.aux.wrap &&
        tx_data_i == r.eos |=> eoi_o [*2])
        else $error("EOI missing on end character.");

    AST_TIMING_WR: assert property (
        commit_w && pwrite_i && idx_w == IDX_TIMING &&
        pwdata_i[7:5] == HOLD_TAG |=> r.hold == $past(pwdata_i[4:0]))
        else $error("Hold field not written.");

    AST_LONG_HOLD: assert property (
        r.src == SRC_SGNS && n.src == SRC_STRS && r.pend_end &&
        eos_match(r.txb, r.eos, r.aux.eight_bit_compare_select) |=> r.tgt == $past(r.long_dly))
        else $error("Long delay not used for end byte.");

    AST_IRQ: assert property (
        irq_o == ((r.istat & r.imask) != '0))
        else $error("Interrupt not raised.");

    COV_BYTE_SENT: cover property (
        r.src == SRC_SGNS ##[1:300] r.src == SRC_STRS ##[1:300]
        r.src == SRC_IDLE);
    COV_POLL: cover property (ppoll_done_i ##[1:20] $rose(pready_o));
    COV_RX_END: cover property (rx_end_o);
    COV_LONG_HOLD: cover property (
        r.src == SRC_STRS && r.pend_end && r.tgt == r.long_dly);

endmodule

// *** verif/ilr_listener_model.sv ***
// Behavioural listener and wired bus lines facing the byte source.
`timescale 1ns/1ps
module ilr_listener_model (
    input  wire logic       clk_i,      // Block clock.
    input  wire logic       srst_i,     // Synchronous reset, high.
    input  wire logic [7:0] dio_oe_i,   // Lines asserted by the block.
    input  wire logic [7:0] ext_i,      // Lines asserted by other devices.
    input  wire logic       dav_i,      // DAV from the source.
    input  wire logic       eoi_i,      // EOI from the source.
    input  wire logic       stall_i,    // Keep the listener not ready.
    output logic      [7:0] dio_o,      // Wired level, 1 asserted.
    output logic            nrfd_o,     // Not ready for data.
    output logic            ndac_o,     // Data not accepted.
    output logic      [7:0] cap_o,      // Last byte taken off the bus.
    output logic            cap_eoi_o   // EOI seen with that byte.
);
    logic [1:0] seen_r;

    // Open-collector lines: any party that asserts a line wins.
    assign dio_o  = dio_oe_i | ext_i;
    // Not ready while stalled or while a byte is still offered.
    assign nrfd_o = stall_i | dav_i;
    // Acceptance comes two cycles late so the source must wait for it.
    assign ndac_o = ~(dav_i & (seen_r == 2'h2));

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            seen_r    <= 2'h0;
            cap_o     <= 8'h00;
            cap_eoi_o <= 1'b0;
        end else begin
            if (!dav_i) begin
                seen_r <= 2'h0;
            end else if (seen_r != 2'h2) begin
                seen_r <= seen_r + 2'h1;
            end
            if (dav_i && seen_r == 2'h0) begin
                cap_o     <= dio_o;
                cap_eoi_o <= eoi_i;
            end
        end
    end
endmodule

// *** verif/ilr_line_regs_test.sv ***
// Self-checking testbench of the line, end-of-string and timing registers.
`timescale 1ns/1ps
module ilr_line_regs_test;
    import ilr_pkg::*;
    localparam logic [3:0] SIG_V = 4'h5;  // Arbitrary value.
    logic        clk, srst, psel, pen, pwr, pready, pslverr, irq, err;
    logic        cmd_vld, pp_vld, rx_vld, rx_end, tx_vld, tx_last, tx_rdy;
    logic        nrfd, ndac, dav, eoi, stall, cap_eoi;
    logic [7:0]  paddr, cmd_data, pp_data, rx_data, tx_data, dio_line;
    logic [7:0]  dio_drv, dio_oe, ext, cap, b, e;
    logic [31:0] pwdata, prdata, rd;
    int          mismatches, total_checks, cyc, su, hd, h, s;

    ilr_line_regs #(.SIG_VERSION(SIG_V), .SIG_LOW(4'h0)) ilr_line_regs_i (
        .core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .cmd_vld_i(cmd_vld), .cmd_data_i(cmd_data),
        .ppoll_done_i(pp_vld), .ppoll_data_i(pp_data), .rx_vld_i(rx_vld),
        .rx_data_i(rx_data), .rx_end_o(rx_end), .tx_vld_i(tx_vld),
        .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_rdy_o(tx_rdy),
        .dio_i(dio_line), .dio_o(dio_drv), .dio_oe_o(dio_oe),
        .nrfd_i(nrfd), .ndac_i(ndac), .dav_o(dav), .eoi_o(eoi));

    ilr_listener_model ilr_listener_model_i (
        .clk_i(clk), .srst_i(srst), .dio_oe_i(dio_oe), .ext_i(ext),
        .dav_i(dav), .eoi_i(eoi), .stall_i(stall), .dio_o(dio_line),
        .nrfd_o(nrfd), .ndac_o(ndac), .cap_o(cap), .cap_eoi_o(cap_eoi));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Durations carry a few cycles of register and sampling delay, hence the window.
    task automatic rng(input int v, input int lo);
        total_checks++;
        if (v < lo || v > lo + 8) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, v, lo);
        end
    endtask

    task automatic apb(input logic w, input logic [5:0] i,
                       input logic [7:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pen    <= 1'b0;
        pwr    <= w;
        paddr  <= {i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    task automatic rchk(input logic [5:0] i, input logic [7:0] x,
                        input logic xe);
        apb(1'b0, i, 8'h00);
        chk(rd[7:0], x);
        chk({7'h00, err}, {7'h00, xe});
    endtask

    task automatic pulse(input int k, input logic [7:0] d);
        @(posedge clk);
        cmd_vld  <= (k == 0);
        pp_vld   <= (k == 1);
        rx_vld   <= (k == 2);
        cmd_data <= d;
        pp_data  <= d;
        rx_data  <= d;
        @(posedge clk);
        cmd_vld <= 1'b0;
        pp_vld  <= 1'b0;
        rx_vld  <= 1'b0;
    endtask

    task automatic send(input logic [7:0] d, input logic last);
        @(posedge clk);
        while (tx_rdy !== 1'b1) @(posedge clk);
        tx_vld  <= 1'b1;
        tx_data <= d;
        tx_last <= last;
        @(posedge clk);
        tx_vld <= 1'b0;
        su = 0;
        hd = 0;
        while (dav !== 1'b1) begin
            @(posedge clk);
            su++;
        end
        while (dav === 1'b1) begin
            @(posedge clk);
            hd++;
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang of any wait lands here; the whole run needs far fewer cycles.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        {srst, psel, pen, pwr, cmd_vld, pp_vld, rx_vld} = 7'h40;
        {tx_vld, tx_last, stall, paddr, cmd_data, pp_data} = 27'h0;
        {rx_data, tx_data, ext, pwdata} = 56'h0;
        void'($urandom(32'hFBEA));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rchk(IDX_PASS, 8'h00, 1'b0);
        rchk(IDX_DATA_IN, 8'h00, 1'b0);
        rchk(IDX_SIG, {SIG_V, 4'h0}, 1'b0);
        apb(1'b1, IDX_SIG, 8'hFF);
        apb(1'b1, IDX_PASS, 8'hFF);
        rchk(IDX_SIG, {SIG_V, 4'h0}, 1'b0);
        rchk(IDX_PASS, 8'h00, 1'b0);
        rchk(IDX_EOS, 8'h00, 1'b0);
        rchk(6'h3F, 8'h00, 1'b1);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            e = 8'($urandom);
            ext <= e;
            apb(1'b1, IDX_DRIVE, b);
            repeat (2) @(posedge clk);
            chk(dio_oe, b);
            chk(dio_drv, 8'h00);
            rchk(IDX_TIMING, b | e, 1'b0);
        end
        apb(1'b1, IDX_AUX, 8'h08);
        repeat (2) @(posedge clk);
        chk(dio_oe, 8'h00);
        apb(1'b1, IDX_AUX, 8'h00);
        apb(1'b1, IDX_DRIVE, 8'h00);
        ext <= 8'h00;
        $display("test lines done");
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            pulse(0, b);
            rchk(IDX_PASS, b, 1'b0);
            b = 8'($urandom);
            pulse(1, b);
            rd = 32'h0;
            for (int n = 0; n < 20 && rd[EV_CMD_OUT] !== 1'b1; n++) begin
                apb(1'b0, IDX_ISTAT, 8'h00);
            end
            rchk(IDX_PASS, b, 1'b0);
            b = 8'($urandom);
            pulse(2, b);
            rchk(IDX_DATA_IN, b, 1'b0);
        end
        $display("test capture done");
        apb(1'b1, IDX_EOS, 8'h8A);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, IDX_AUX, (k == 2) ? 8'h00 : {5'h00, k[0], 2'h1});
            pulse(2, 8'h0A);
            @(posedge clk);
            chk({7'h00, rx_end}, {7'h00, k == 0});
            pulse(2, 8'h8A);
            @(posedge clk);
            chk({7'h00, rx_end}, {7'h00, k != 2});
        end
        $display("test end compare done");
        apb(1'b1, IDX_ISTAT, 8'h0F);
        apb(1'b1, IDX_IMASK, 8'h02);
        pulse(0, 8'h3C);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h01);
        rchk(IDX_ISTAT, 8'h02, 1'b0);
        apb(1'b1, IDX_ISTAT, 8'h02);
        apb(1'b1, IDX_IMASK, 8'h00);
        pulse(0, 8'h3D);
        repeat (2) @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        apb(1'b1, IDX_ISTAT, 8'h0F);
        $display("test interrupt done");
        for (int i = 0; i < 4; i++) begin
            h = $urandom_range(31);
            s = (i == 3) ? 31 : $urandom_range(31);
            b = 8'($urandom);
            apb(1'b1, IDX_TIMING, {HOLD_TAG, h[4:0]});
            apb(1'b1, IDX_TIMING, {SETUP_TAG, s[4:0]});
            apb(1'b1, IDX_HSCTL, {1'b1, 2'h0, i[0], 4'h0});
            send(b, 1'b0);
            rng(su, TICK_CYC * (i[0] ? 3 : 4 + s));
            rng(hd, TICK_CYC * (2 + h));
            chk(cap, b);
        end
        $display("test timing done");
        apb(1'b1, IDX_AUX, 8'h02);
        apb(1'b1, IDX_EOS, 8'h55);
        apb(1'b1, IDX_HSCTL, 8'h81);
        send(8'h55, 1'b0);
        chk({7'h00, cap_eoi}, 8'h01);
        rng(hd, TICK_CYC * LONG_DLY_RST);
        send(8'h54, 1'b0);
        chk({7'h00, cap_eoi}, 8'h00);
        rng(hd, TICK_CYC * (2 + h));
        apb(1'b1, IDX_HSCTL, 8'h00);
        apb(1'b1, IDX_ISTAT, 8'h0F);
        stall <= 1'b1;
        fork
            begin
                repeat (40) @(posedge clk);
                stall <= 1'b0;
            end
        join_none
        send(8'h54, 1'b1);
        chk({7'h00, cap_eoi}, 8'h01);
        chk(cap, 8'h54);
        repeat (4) @(posedge clk);
        rchk(IDX_ISTAT, 8'h08, 1'b0);
        $display("test end of string send done");
        report_and_stop();
    end
endmodule
